// [hdl/mode_cfg_pkg.sv]
package mode_cfg_pkg;

    // Command pin encoding: active-low row strobe, column strobe, write enable
    localparam logic [2:0] CMD_CONFIG_WRITE = 3'b000;
    localparam logic [2:0] CMD_ACTIVATE     = 3'b011;
    localparam logic [2:0] CMD_READ         = 3'b101;
    localparam logic [2:0] CMD_WRITE        = 3'b100;

    // Configuration word select codes, bits 20:18
    localparam int          SEL_HI             = 20;
    localparam int          SEL_LO             = 18;
    localparam logic [2:0]  SEL_BASE_WORD      = 3'h0;
    localparam logic [2:0]  SEL_FIRST_WORD     = 3'h1;
    localparam logic [2:0]  SEL_SECOND_WORD    = 3'h2;
    localparam logic [2:0]  SEL_DO_NOT_USE     = 3'h7;

    // Second configuration word register index
    localparam logic [3:0]  WRITE_LATENCY_TERMINATION_CONFIG_OFFSET = 4'h2;
    localparam int          SECOND_WORD_WIDTH  = 18;

    // First configuration word fields
    localparam int HOLD_DELAY_HI      = 4;
    localparam int HOLD_DELAY_LO      = 3;
    localparam int STROBE_TERM_BIT    = 11;
    localparam int OUTPUT_DISABLE_BIT = 12;

    // Second configuration word fields
    localparam int WRITE_CRC_BIT      = 12;
    localparam int WRITE_TERM_HI      = 11;
    localparam int WRITE_TERM_LO      = 9;
    localparam int REFRESH_RANGE_HI   = 7;
    localparam int REFRESH_RANGE_LO   = 6;
    localparam int WRITE_COL_HI       = 5;
    localparam int WRITE_COL_LO       = 3;
    localparam logic [21:0] SECOND_WORD_RESERVED_MASK = 22'h222107;

    // Base word read column latency field (plain binary, our placement)
    localparam int READ_COL_HI        = 6;
    localparam int READ_COL_LO        = 2;

    // Reset values
    localparam logic [1:0] HOLD_DELAY_RESET  = 2'h0;
    localparam logic [4:0] READ_COL_RESET    = 5'h09;
    localparam logic [2:0] WRITE_COL_RESET   = 3'h0;
    localparam logic [2:0] WRITE_TERM_RESET  = 3'h0;
    localparam logic [1:0] REFRESH_RESET     = 2'h0;

    // Hold delay line depth in cycles
    localparam int HOLD_LINE_DEPTH = 32;

    // Termination settings
    typedef enum logic [2:0] {
        TERM_UNCHANGED, TERM_120_OHM, TERM_240_OHM, TERM_HIGH_Z, TERM_80_OHM, TERM_RESERVED
    } write_termination_type;

    typedef enum logic [1:0] {
        RANGE_NORMAL, RANGE_REDUCED, RANGE_EXTENDED, RANGE_AUTOMATIC
    } refresh_range_type;

endpackage

// [hdl/command_hold_line.sv]
`timescale 1ns/100ps
`default_nettype none
// Shift line that delays a command by a run-time selected number of cycles
module command_hold_line
    import mode_cfg_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             valid_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic [4:0]       delay_i,
    output logic                  valid_o,
    output logic [WIDTH-1:0]      data_o
);

    typedef struct packed {
        logic [DEPTH-1:0]            valid;
        logic [DEPTH-1:0][WIDTH-1:0] data;
        logic                        out_valid;
        logic [WIDTH-1:0]            out_data;
    } line_state_type;

    line_state_type state_reg;
    line_state_type state_next;

    // Stage 0 takes the input; output taps stage delay-1, or input for zero
    always_comb begin
        state_next       = state_reg;
        state_next.valid = {state_reg.valid[DEPTH-2:0], valid_i};
        state_next.data  = {state_reg.data[DEPTH-2:0], data_i};
        if (delay_i == 5'h00) begin
            state_next.out_valid = valid_i;
            state_next.out_data  = data_i;
        end else begin
            state_next.out_valid = state_reg.valid[delay_i - 5'h01];
            state_next.out_data  = state_reg.data[delay_i - 5'h01];
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign valid_o = state_reg.out_valid;
    assign data_o  = state_reg.out_data;

endmodule
`default_nettype wire

// [hdl/sdram_mode_latency_config.sv]
`timescale 1ns/100ps
`default_nettype none
module sdram_mode_latency_config
    import mode_cfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [1:0]  bank_group_pins_i,
    input  wire logic [1:0]  bank_i,
    input  wire logic [17:0] addr_i,
    input  wire logic        two_clock_preamble_i,
    input  wire logic        byte_mask_request_i,
    input  wire logic        write_inversion_request_i,
    input  wire logic        read_inversion_request_i,
    input  wire logic        data_drive_i,
    input  wire logic        strobe_drive_i,
    output logic             data_drive_en_o,
    output logic             strobe_drive_en_o,
    output logic             strobe_termination_o,
    output logic             extra_strobe_termination_o,
    output logic             write_byte_mask_en_o,
    output logic             write_bus_inversion_en_o,
    output logic             read_bus_inversion_en_o,
    output logic             internal_cmd_valid_o,
    output logic [2:0]       internal_cmd_o,
    output logic [5:0]       total_read_latency_o,
    output logic [5:0]       total_write_latency_o,
    output logic [4:0]       command_hold_delay_o,
    output logic [4:0]       write_column_latency_o,
    output logic             write_column_latency_bad_o,
    output logic             write_crc_en_o,
    output write_termination_type write_termination_o,
    output refresh_range_type low_power_refresh_range_o,
    output logic             reserved_bits_error_o
);

    typedef struct packed {
        logic [2:0]  cmd_s1;
        logic [2:0]  cmd_s2;
        logic [21:0] word_s1;
        logic [21:0] word_s2;
        logic [1:0]  hold_code;
        logic        output_disable;
        logic        strobe_term;
        logic [4:0]  read_col;
        logic [2:0]  write_col_code;
        logic [2:0]  write_term_code;
        logic [1:0]  refresh_code;
        logic        write_crc;
        logic        reserved_error;
        logic        byte_mask;
        logic        write_inv;
        logic        read_inv;
    } cfg_state_type;

    cfg_state_type state_reg;
    cfg_state_type state_next;

    logic [2:0]  cmd_now;
    logic [2:0]  word_sel;
    logic [4:0]  hold_cycles;
    logic [4:0]  write_cycles;
    logic        write_bad;
    logic        hold_valid_out;

    // Write column latency lookup, used for both preamble modes
    function automatic logic [4:0] write_col_cycles(input logic [2:0] code);
        case (code)
            3'h0:    write_col_cycles = 5'h09;
            3'h1:    write_col_cycles = 5'h0A;
            3'h2:    write_col_cycles = 5'h0B;
            3'h3:    write_col_cycles = 5'h0C;
            3'h4:    write_col_cycles = 5'h0E;
            3'h5:    write_col_cycles = 5'h10;
            3'h6:    write_col_cycles = 5'h12;
            default: write_col_cycles = 5'h14;
        endcase
    endfunction

    // Synchronised pin view: command and the word formed by all address pins
    assign cmd_now  = state_reg.cmd_s2;
    assign word_sel = state_reg.word_s2[SEL_HI:SEL_LO];

    always_comb begin
        case (state_reg.hold_code)
            2'h1:    hold_cycles = state_reg.read_col - 5'h01;
            2'h2:    hold_cycles = state_reg.read_col - 5'h02;
            default: hold_cycles = 5'h00; // Off, and reserved treated as off
        endcase
    end

    always_comb begin
        write_cycles = write_col_cycles(state_reg.write_col_code);
        write_bad    = two_clock_preamble_i && !state_reg.write_col_code[2];
    end

    // Next state: synchronisers and configuration capture
    always_comb begin
        state_next         = state_reg;
        state_next.cmd_s1  = {ras_n_i, cas_n_i, we_n_i};
        state_next.cmd_s2  = state_reg.cmd_s1;
        state_next.word_s1 = {bank_group_pins_i, bank_i, addr_i};
        state_next.word_s2 = state_reg.word_s1;
        if (cmd_now == CMD_CONFIG_WRITE) begin
            case (word_sel)
                SEL_BASE_WORD: begin
                    state_next.read_col = state_reg.word_s2[READ_COL_HI:READ_COL_LO];
                end
                SEL_FIRST_WORD: begin
                    state_next.hold_code      = state_reg.word_s2[HOLD_DELAY_HI:HOLD_DELAY_LO];
                    state_next.output_disable = state_reg.word_s2[OUTPUT_DISABLE_BIT];
                    state_next.strobe_term    = state_reg.word_s2[STROBE_TERM_BIT];
                end
                SEL_SECOND_WORD: begin
                    state_next.write_crc       = state_reg.word_s2[WRITE_CRC_BIT];
                    state_next.write_term_code = state_reg.word_s2[WRITE_TERM_HI:WRITE_TERM_LO];
                    state_next.refresh_code    =
                        state_reg.word_s2[REFRESH_RANGE_HI:REFRESH_RANGE_LO];
                    state_next.write_col_code  = state_reg.word_s2[WRITE_COL_HI:WRITE_COL_LO];
                    state_next.reserved_error  =
                        |(state_reg.word_s2 & SECOND_WORD_RESERVED_MASK);
                end
                default: begin
                    state_next.read_col = state_reg.read_col;
                end
            endcase
        end
        // shared pin function selection
        // New termination setting applies at the same edge, so no lag cycle
        if (state_next.strobe_term) begin
            state_next.byte_mask = 1'b0;
            state_next.write_inv = 1'b0;
            state_next.read_inv  = 1'b0;
        end else begin
            state_next.byte_mask = byte_mask_request_i;
            state_next.write_inv = write_inversion_request_i && !byte_mask_request_i;
            state_next.read_inv  = read_inversion_request_i;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg                 <= '0;
            state_reg.cmd_s1          <= 3'h7;
            state_reg.cmd_s2          <= 3'h7;
            state_reg.hold_code       <= HOLD_DELAY_RESET;
            state_reg.read_col        <= READ_COL_RESET;
            state_reg.write_col_code  <= WRITE_COL_RESET;
            state_reg.write_term_code <= WRITE_TERM_RESET;
            state_reg.refresh_code    <= REFRESH_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // hold reads and writes by the delay
    command_hold_line #(
        .WIDTH (3),
        .DEPTH (HOLD_LINE_DEPTH)
    ) u_hold (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .valid_i (cmd_now == CMD_READ || cmd_now == CMD_WRITE),
        .data_i  (cmd_now),
        .delay_i (hold_cycles),
        .valid_o (hold_valid_out),
        .data_o  (internal_cmd_o)
    );
    assign internal_cmd_valid_o = hold_valid_out;

    assign total_read_latency_o  = {1'b0, hold_cycles} + {1'b0, state_reg.read_col};
    assign total_write_latency_o = {1'b0, hold_cycles} + {1'b0, write_cycles};

    assign data_drive_en_o   = data_drive_i && !state_reg.output_disable;
    assign strobe_drive_en_o = strobe_drive_i && !state_reg.output_disable;

    assign strobe_termination_o       = state_reg.strobe_term && !state_reg.output_disable;
    assign extra_strobe_termination_o = state_reg.strobe_term && !state_reg.output_disable;

    assign write_byte_mask_en_o       = state_reg.byte_mask;
    assign write_bus_inversion_en_o   = state_reg.write_inv;
    assign read_bus_inversion_en_o    = state_reg.read_inv;
    assign command_hold_delay_o       = hold_cycles;
    assign write_column_latency_o     = write_bad ? 5'h00 : write_cycles;
    assign write_column_latency_bad_o = write_bad;
    assign write_crc_en_o             = state_reg.write_crc;
    assign reserved_bits_error_o      = state_reg.reserved_error;

    always_comb begin
        case (state_reg.write_term_code)
            3'h0:    write_termination_o = TERM_UNCHANGED;
            3'h1:    write_termination_o = TERM_120_OHM;
            3'h2:    write_termination_o = TERM_240_OHM;
            3'h3:    write_termination_o = TERM_HIGH_Z;
            3'h4:    write_termination_o = TERM_80_OHM;
            default: write_termination_o = TERM_RESERVED;
        endcase
        low_power_refresh_range_o = refresh_range_type'(state_reg.refresh_code);
    end

endmodule
`default_nettype wire

// [verification/mode_cfg_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the mode configuration block
module mode_cfg_chk
    import mode_cfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [1:0]  bank_group_pins_i,
    input  wire logic [1:0]  bank_i,
    input  wire logic [17:0] addr_i,
    input  wire logic        data_drive_i,
    input  wire logic        data_drive_en_o,
    input  wire logic        strobe_termination_o,
    input  wire logic        extra_strobe_termination_o,
    input  wire logic        write_byte_mask_en_o,
    input  wire logic        write_bus_inversion_en_o,
    input  wire logic        read_bus_inversion_en_o,
    input  wire logic        internal_cmd_valid_o,
    input  wire logic [2:0]  internal_cmd_o,
    input  wire logic [5:0]  total_write_latency_o,
    input  wire logic [4:0]  command_hold_delay_o,
    input  wire logic [4:0]  write_column_latency_o,
    input  wire logic        write_column_latency_bad_o,
    input  wire logic        write_crc_en_o,
    input  wire write_termination_type write_termination_o,
    input  wire refresh_range_type     low_power_refresh_range_o
);
    logic [2:0] cmd;
    logic       second_wr;
    logic       rw_cmd;
    // Decode of the command pins as sampled
    assign cmd = {ras_n_i, cas_n_i, we_n_i};
    assign second_wr = cmd == CMD_CONFIG_WRITE &&
        {bank_group_pins_i[0], bank_i} == SEL_SECOND_WORD;
    assign rw_cmd = cmd == CMD_READ || cmd == CMD_WRITE;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    AST_CRC_LOAD: assert property (second_wr |-> ##3
        write_crc_en_o == $past(addr_i[12], 3))
        else $error("crc enable not loaded");
    AST_TERM_LOAD: assert property (second_wr |-> ##3 write_termination_o ==
        (($past(addr_i[11:9], 3) > 3'h4) ? 3'h5 : $past(addr_i[11:9], 3)))
        else $error("write termination decode wrong");
    AST_RANGE_LOAD: assert property (second_wr |-> ##3
        low_power_refresh_range_o == $past(addr_i[7:6], 3))
        else $error("refresh range not loaded");
    AST_RETAIN: assert property (($changed(write_crc_en_o) ||
        $changed(low_power_refresh_range_o)) |-> $past(second_wr, 3))
        else $error("second word field changed without a write");
    AST_WL_SUM: assert property (!write_column_latency_bad_o |->
        total_write_latency_o == 6'(command_hold_delay_o) + 6'(write_column_latency_o))
        else $error("write latency is not the sum");
    AST_OFF: assert property ((data_drive_i && !data_drive_en_o) |->
        !strobe_termination_o && !extra_strobe_termination_o)
        else $error("termination left on while outputs disabled");
    AST_SHARED: assert property (extra_strobe_termination_o |->
        !write_byte_mask_en_o && !write_bus_inversion_en_o && !read_bus_inversion_en_o)
        else $error("shared pin functions on with termination");
    AST_EXCL: assert property (!(write_byte_mask_en_o && write_bus_inversion_en_o))
        else $error("byte mask and write inversion together");
    AST_CMD_NOW: assert property ((rw_cmd && command_hold_delay_o == 5'h00) |-> ##3
        internal_cmd_valid_o && internal_cmd_o == $past(cmd, 3))
        else $error("command not issued on time");
endmodule
`default_nettype wire

// [verification/mode_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Controller model driving command and address pins
module mode_ctrl_model
    import mode_cfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [2:0]  cmd_i,
    input  wire logic [21:0] word_i,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic [1:0]       bank_group_pins_o,
    output logic [1:0]       bank_o,
    output logic [17:0]      addr_o
);
    logic [21:0] word;
    logic [21:0] last = 22'h000000;
    assign word = (word_i[SEL_HI:SEL_LO] == SEL_SECOND_WORD) ?
        (word_i & ~SECOND_WORD_RESERVED_MASK) : word_i;
    // write latency codes pass unchanged; codes 0 to 3 are flagged bad when two_clock_preamble_i is set
    // strobes and word; idle address shows inverse of last
    assign {ras_n_o, cas_n_o, we_n_o} = req_i ? cmd_i : 3'h7;
    assign {bank_group_pins_o, bank_o, addr_o} = req_i ? word : ~last;
    // Remember last driven word
    always_ff @(posedge clk_i) begin
        if (req_i) begin
            last <= word;
        end
    end
endmodule
`default_nettype wire

// [verification/sdram_mode_latency_config_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// Bench for the mode configuration block
module sdram_mode_latency_config_tb_top;
    import mode_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i, ras_n_i, cas_n_i, we_n_i, two_clock_preamble_i, data_drive_i, strobe_drive_i;
    logic byte_mask_request_i, write_inversion_request_i, read_inversion_request_i;
    logic [1:0] bank_group_pins_i, bank_i;
    logic [17:0] addr_i;
    logic data_drive_en_o, strobe_drive_en_o, strobe_termination_o, extra_strobe_termination_o;
    logic write_byte_mask_en_o, write_bus_inversion_en_o, read_bus_inversion_en_o;
    logic internal_cmd_valid_o, write_column_latency_bad_o, write_crc_en_o, reserved_bits_error_o;
    logic [2:0] internal_cmd_o, cmd_sel;
    logic [5:0] total_read_latency_o, total_write_latency_o;
    logic [4:0] command_hold_delay_o, write_column_latency_o;
    write_termination_type write_termination_o;
    refresh_range_type low_power_refresh_range_o;
    logic req;
    logic [21:0] word;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int e;
    logic [4:0] cwl_tab [8] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14};
    sdram_mode_latency_config dut_u (.*);
    mode_ctrl_model ctrl_u (.clk_i(clk_i), .req_i(req), .cmd_i(cmd_sel), .word_i(word),
        .ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i),
        .bank_group_pins_o(bank_group_pins_i), .bank_o(bank_i), .addr_o(addr_i));
    // Clock and cycle ceiling
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [5:0] x, input logic [5:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", n, x, g);
        end
    endtask
    task automatic send(input logic [2:0] c, input logic [21:0] w);
        @(negedge clk_i);
        req = 1'b1;
        cmd_sel = c;
        word = w;
    endtask
    task automatic cfg(input logic [2:0] s, input logic [17:0] a);
        send(CMD_CONFIG_WRITE, {1'b0, s, a});
        @(negedge clk_i);
        req = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    // Activate then read or write at once; count cycles to the internal issue
    task automatic rw(input logic [2:0] c, input int x);
        int n;
        send(CMD_ACTIVATE, 22'h000000);
        send(c, 22'h000000);
        @(negedge clk_i);
        req = 1'b0;
        n = 1;
        while (!(internal_cmd_valid_o === 1'b1 && internal_cmd_o === c) && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("cmd_delay", 6'(x), 6'(n));
    endtask
    task automatic summarize;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {srst_i, cmd_sel, word} = '1;
        {req, two_clock_preamble_i, byte_mask_request_i} = 3'h0;
        {write_inversion_request_i, read_inversion_request_i} = 2'h0;
        {data_drive_i, strobe_drive_i} = 2'h3;
        repeat (16) @(negedge clk_i);
        srst_i = 1'b0;
        chk("wterm", 6'(TERM_UNCHANGED), 6'(write_termination_o));
        chk("rl", 6'h09, total_read_latency_o);
        chk("wl", 6'h09, total_write_latency_o);
        for (int p = 0; p < 2; p++) begin
            two_clock_preamble_i = p[0];
            for (int c = 0; c < 8; c++) begin
                cfg(SEL_SECOND_WORD, {5'h00, c[0], c[2:0], 1'b0, c[1:0], c[2:0], 3'h0});
                e = (p == 1 && c < 4) ? 0 : cwl_tab[c];
                chk("wcl", 6'(e), 6'(write_column_latency_o));
                chk("wcl_bad", 6'(p == 1 && c < 4), 6'(write_column_latency_bad_o));
                chk("wterm", 6'((c > 4) ? 5 : c), 6'(write_termination_o));
                chk("range", 6'(c % 4), 6'(low_power_refresh_range_o));
                chk("crc", 6'(c % 2), 6'(write_crc_en_o));
            end
        end
        two_clock_preamble_i = 1'b0;
        cfg(SEL_DO_NOT_USE, 18'h00000);
        chk("wcl", 6'h14, 6'(write_column_latency_o));
        for (int h = 0; h < 4; h++) begin
            cfg(SEL_FIRST_WORD, 18'(h << 3));
            e = (h == 1) ? 8 : ((h == 2) ? 7 : 0);
            chk("hold", 6'(e), 6'(command_hold_delay_o));
            chk("rl", 6'(e + 9), total_read_latency_o);
            chk("wl", 6'(e + 20), total_write_latency_o);
            chk("crc", 6'h01, 6'(write_crc_en_o));
            rw(h[0] ? CMD_READ : CMD_WRITE, e + 3);
        end
        {byte_mask_request_i, write_inversion_request_i, read_inversion_request_i} = 3'h7;
        // extra termination only as on an eight-bit part
        cfg(SEL_FIRST_WORD, 18'h00800);
        chk("mask", 6'h00, 6'(write_byte_mask_en_o));
        chk("winv", 6'h00, 6'(write_bus_inversion_en_o));
        chk("rinv", 6'h00, 6'(read_bus_inversion_en_o));
        chk("sterm", 6'h01, 6'(strobe_termination_o));
        chk("xterm", 6'h01, 6'(extra_strobe_termination_o));
        cfg(SEL_FIRST_WORD, 18'h00000);
        chk("mask", 6'h01, 6'(write_byte_mask_en_o));
        chk("winv", 6'h00, 6'(write_bus_inversion_en_o));
        chk("rinv", 6'h01, 6'(read_bus_inversion_en_o));
        byte_mask_request_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk("winv", 6'h01, 6'(write_bus_inversion_en_o));
        cfg(SEL_FIRST_WORD, 18'h01800);
        chk("data_en", 6'h00, 6'(data_drive_en_o));
        chk("strobe_en", 6'h00, 6'(strobe_drive_en_o));
        chk("sterm", 6'h00, 6'(strobe_termination_o));
        chk("xterm", 6'h00, 6'(extra_strobe_termination_o));
        cfg(SEL_FIRST_WORD, 18'h00000);
        chk("data_en", 6'h01, 6'(data_drive_en_o));
        chk("rsv_err", 6'h00, 6'(reserved_bits_error_o));
        // Base word sets read column latency 12, then hold code 01 follows it
        cfg(SEL_BASE_WORD, 18'h00030);
        chk("rl", 6'h0C, total_read_latency_o);
        chk("hold", 6'h00, 6'(command_hold_delay_o));
        cfg(SEL_FIRST_WORD, 18'h00008);
        chk("hold", 6'h0B, 6'(command_hold_delay_o));
        chk("rl", 6'h17, total_read_latency_o);
        chk("wl", 6'h1F, total_write_latency_o);
        rw(CMD_READ, 14);
        summarize();
    end
endmodule
bind sdram_mode_latency_config mode_cfg_chk chk_u (.*);
`default_nettype wire
